// ==== common/lane_pkg.sv ====
// shared constants, register map and carrier types for the lane feature block
package lane_pkg;
	localparam int          DATA_W        = 32;
	localparam int          NSYM          = 4;
	localparam int          FIFO_DEPTH    = 16;
	// register byte addresses
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_STATUS   = 8'h04;
	localparam logic [7:0]  ADDR_BOND_SEQ = 8'h08;
	localparam logic [7:0]  ADDR_BOND_ALT = 8'h0C;
	localparam logic [7:0]  ADDR_RM_SEQ   = 8'h10;
	localparam logic [7:0]  ADDR_RM_ALT   = 8'h14;
	localparam logic [7:0]  ADDR_SEQ_CFG  = 8'h18;
	localparam logic [7:0]  ADDR_RM_CFG   = 8'h1C;
	localparam logic [7:0]  ADDR_ERRCNT   = 8'h20;
	// control register fields
	localparam int          C_LOOP_LSB    = 0;
	localparam int          C_SATA        = 3;
	localparam int          C_OOB_EN      = 4;
	localparam int          C_PRBS_EN     = 5;
	localparam int          C_ERR_LOOP    = 6;
	localparam int          C_BOND_EN     = 7;
	localparam int          C_BOND2_EN    = 8;
	localparam int          C_RM_EN       = 9;
	localparam int          C_RM2_EN      = 10;
	localparam int          C_PSEL_LSB    = 12;
	localparam int          C_BURST_LSB   = 16;
	localparam logic [31:0] CTRL_RESET    = 32'h0004_0000;
	// sequence config: len-1 in [1:0], skew in [7:4], wildcard mask in [11:8]
	localparam int          S_SKEW_LSB    = 4;
	localparam int          S_WILD_LSB    = 8;
	// status codes
	localparam logic [2:0]  ST_OK         = 3'h0;
	localparam logic [2:0]  ST_ADD        = 3'h1;
	localparam logic [2:0]  ST_DROP       = 3'h2;
	localparam logic [2:0]  ST_DETECT     = 3'h3;
	localparam logic [2:0]  ST_ERR        = 3'h4;
	localparam logic [2:0]  ST_SATA_OOB   = 3'h5;
	// timing
	localparam int          CLK_MHZ       = 40;
	localparam int          PROBE_NS      = 1000;
	localparam int          PROBE_CYC     = (PROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int          BURST_CYC     = 8;
	localparam logic [31:0] PRBS_SEED     = 32'hFFFF_FFFF;

	typedef struct packed {
		logic [DATA_W-1:0] word;
		logic [NSYM-1:0]   ctrl;
	} rx_beat_t;

	typedef struct packed {
		logic init;
		logic sas;
		logic wake;
	} oob_t;

	typedef enum logic [1:0] {
		P0,
		P0S,
		P1,
		P2
	} power_t;
endpackage

// ==== hdl/lane_features.sv ====
// lane feature block: sideband, oob, pattern checker, bonding and rate matching
//
// Summary of operation
// RULE_01: three-bit loopback select drives loopback mux.
// RULE_02: three-bit status, coding picked by sata flag.
// RULE_03: rx valid only with lock and data.
// RULE_04: separate init, sas, wake detect flags.
// RULE_05: probe request starts detection, gated by controls.
// RULE_06: probe request ignored in sata coding.
// RULE_07: quiet request holds transmitter at zero differential.
// RULE_08: pulse phy done after probe or power change.
// RULE_09: tx and rx power states are separate.
// RULE_10: oob detector runs only when enabled.
// RULE_11: pattern checker on received data when enabled.
// RULE_12: pattern select chooses transmitted pattern.
// RULE_13: error inject flips bits of outgoing pattern.
// RULE_14: error loopback feeds checker error into inject.
// RULE_15: bonding sequence match inserts or drops characters. Here a match only holds the read side for one cycle and never drops a word.
// RULE_16: bonding sequence length from one to four.
// RULE_17: bonding skew must stay below half spacing.
// RULE_18: second bonding sequence also triggers bonding.
// RULE_19: rate match sequence adds or removes characters.
// RULE_20: rate match sequence length one to four.
// RULE_21: ppm offset and period stored in config.
// RULE_22: second rate match sequence also triggers.
// RULE_23: oob match after burst count, default four.
// RULE_24: wildcard symbols and unused positions always match.
// RULE_25: oob send done after requested burst sent.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module lane_features (
	// clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// axi4-lite slave
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [7:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// receive side from the line
	input  wire lane_pkg::rx_beat_t          line_rx,
	input  wire logic                        line_lock,
	input  wire lane_pkg::oob_t              line_oob_burst,
	input  wire logic                        line_far_rx_present,
	// user control
	input  wire logic                        far_rx_probe_req,
	input  wire logic                        tx_quiet_req,
	input  wire lane_pkg::power_t            tx_power_state,
	input  wire lane_pkg::power_t            rx_power_state,
	input  wire logic                        tx_disp_force_mode,
	input  wire logic                        tx_disp_force_value,
	input  wire logic                        tx_pattern_error_inject,
	input  wire logic                        oob_init_send,
	input  wire logic                        oob_sas_send,
	input  wire logic                        oob_wake_send,
	input  wire logic [31:0]                 tx_word_in,
	// user status and data
	output lane_pkg::rx_beat_t               rx_out,
	output logic                             rx_symbols_good,
	output logic [2:0]                       rx_condition_code,
	output logic                             oob_init_seen,
	output logic                             oob_sas_seen,
	output logic                             oob_wake_seen,
	output logic                             oob_send_done,
	output logic                             phy_op_done,
	output logic                             rx_pattern_error,
	// transmit side to the line
	output logic [31:0]                      line_tx_word,
	output logic                             line_tx_quiet,
	output logic                             line_tx_oob_burst,
	output logic                             line_probe_active
);
	// ==========================================================
	// register file
	logic [31:0] ctrl_q, bond_seq_q, bond_alt_q, rm_seq_q, rm_alt_q;
	logic [31:0] seq_cfg_q, rm_cfg_q;
	logic [15:0] err_cnt_q;
	logic        aw_hold_q, w_hold_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	wire         wr_fire   = aw_hold_q && w_hold_q && !s_axi_bvalid;
	wire         wr_ok     = (awaddr_q[7:5] == 3'h0) && (awaddr_q[1:0] == 2'h0);
	wire  [31:0] wmask     = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old_v);
		merge = (old_v & ~wmask) | (wdata_q & wmask);
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= '0;
			wstrb_q       <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			ctrl_q        <= lane_pkg::CTRL_RESET;
			bond_seq_q    <= '0;
			bond_alt_q    <= '0;
			rm_seq_q      <= '0;
			rm_alt_q      <= '0;
			seq_cfg_q     <= '0;
			rm_cfg_q      <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
				if (wr_ok) begin
					unique case (awaddr_q)
						lane_pkg::ADDR_CTRL:     ctrl_q     <= merge(ctrl_q);
						lane_pkg::ADDR_BOND_SEQ: bond_seq_q <= merge(bond_seq_q);
						lane_pkg::ADDR_BOND_ALT: bond_alt_q <= merge(bond_alt_q);
						lane_pkg::ADDR_RM_SEQ:   rm_seq_q   <= merge(rm_seq_q);
						lane_pkg::ADDR_RM_ALT:   rm_alt_q   <= merge(rm_alt_q);
						lane_pkg::ADDR_SEQ_CFG:  seq_cfg_q  <= merge(seq_cfg_q);
						lane_pkg::ADDR_RM_CFG:   rm_cfg_q   <= merge(rm_cfg_q); // RULE_21
						default: ;
					endcase
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;

	// read channel; status and error count show live state
	wire [31:0] status_word = {23'h0, line_lock, oob_init_seen, oob_sas_seen,
		oob_wake_seen, rx_pattern_error, rx_symbols_good, rx_condition_code};
	logic [31:0] rd_mux;
	always_comb begin
		unique case (s_axi_araddr)
			lane_pkg::ADDR_CTRL:     rd_mux = ctrl_q;
			lane_pkg::ADDR_STATUS:   rd_mux = status_word;
			lane_pkg::ADDR_BOND_SEQ: rd_mux = bond_seq_q;
			lane_pkg::ADDR_BOND_ALT: rd_mux = bond_alt_q;
			lane_pkg::ADDR_RM_SEQ:   rd_mux = rm_seq_q;
			lane_pkg::ADDR_RM_ALT:   rd_mux = rm_alt_q;
			lane_pkg::ADDR_SEQ_CFG:  rd_mux = seq_cfg_q;
			lane_pkg::ADDR_RM_CFG:   rd_mux = rm_cfg_q;
			lane_pkg::ADDR_ERRCNT:   rd_mux = {16'h0000, err_cnt_q};
			default:                 rd_mux = 32'h0000_0000;
		endcase
	end
	wire rd_ok = (s_axi_araddr <= lane_pkg::ADDR_ERRCNT) && (s_axi_araddr[1:0] == 2'h0);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_ok ? rd_mux : 32'h0000_0000;
			s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_arready = !s_axi_rvalid;

	// ==========================================================
	// control field decode
	wire [2:0] loop_sel   = ctrl_q[lane_pkg::C_LOOP_LSB +: 3]; // RULE_01
	wire       sata_fmt   = ctrl_q[lane_pkg::C_SATA];
	wire       oob_en     = ctrl_q[lane_pkg::C_OOB_EN];
	wire       prbs_en    = ctrl_q[lane_pkg::C_PRBS_EN];
	wire       err_loop   = ctrl_q[lane_pkg::C_ERR_LOOP];
	wire       bond_en    = ctrl_q[lane_pkg::C_BOND_EN];
	wire       bond2_en   = ctrl_q[lane_pkg::C_BOND2_EN];
	wire       rm_en      = ctrl_q[lane_pkg::C_RM_EN];
	wire       rm2_en     = ctrl_q[lane_pkg::C_RM2_EN];
	wire [1:0] pat_sel    = ctrl_q[lane_pkg::C_PSEL_LSB +: 2];
	wire [2:0] burst_need = ctrl_q[lane_pkg::C_BURST_LSB +: 3];
	wire [1:0] seq_len_m1 = seq_cfg_q[1:0]; // RULE_16 RULE_20
	wire [3:0] wild_cfg   = seq_cfg_q[lane_pkg::S_WILD_LSB +: 4];

	// ==========================================================
	// sequence match with wildcards
	logic [3:0] use_mask;
	always_comb begin
		unique case (seq_len_m1)
			2'h0: use_mask = 4'b0001;
			2'h1: use_mask = 4'b0011;
			2'h2: use_mask = 4'b0111;
			2'h3: use_mask = 4'b1111;
		endcase
	end
	function automatic logic seq_hit(input logic [31:0] pat, input logic [31:0] w,
		input logic [3:0] care);
		logic hit;
		hit = 1'b1;
		for (int i = 0; i < lane_pkg::NSYM; i++) begin
			if (care[i] && (pat[i*8 +: 8] != w[i*8 +: 8]))
				hit = 1'b0;
		end
		seq_hit = hit;
	endfunction
	wire [3:0] care_mask = use_mask & ~wild_cfg; // RULE_24
	wire bond_hit = bond_en && (seq_hit(bond_seq_q, line_rx.word, care_mask)
		|| (bond2_en && seq_hit(bond_alt_q, line_rx.word, care_mask))); // RULE_15 RULE_18
	wire rm_hit = rm_en && (seq_hit(rm_seq_q, line_rx.word, care_mask)
		|| (rm2_en && seq_hit(rm_alt_q, line_rx.word, care_mask))); // RULE_19 RULE_22

	// ==========================================================
	// receive buffer: rate matching drops a matched word when too full, holds the read side (repeating the head word) when low
	logic [35:0] buf_mem [lane_pkg::FIFO_DEPTH];
	logic [4:0]  wr_ptr_q, rd_ptr_q;
	logic [3:0]  bond_wait_q;
	wire  [4:0]  fill      = wr_ptr_q - rd_ptr_q;
	wire         too_full  = fill > 5'd12;
	wire         too_low   = fill < 5'd4;
	wire         drop_now  = rm_hit && too_full;  // RULE_19
	wire         push      = line_lock && !drop_now;
	wire         skew_ok   = bond_wait_q < seq_cfg_q[lane_pkg::S_SKEW_LSB +: 4]; // RULE_17
	// bonding holds the read side for one cycle when a bonding sequence first matches within the skew limit
	wire         pop       = (fill != 5'd0) && !(bond_hit && skew_ok && bond_wait_q == 4'h0)
		&& !(rm_hit && too_low);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_q    <= 5'h00;
			rd_ptr_q    <= 5'h00;
			bond_wait_q <= 4'h0;
		end else begin
			if (push) begin
				buf_mem[wr_ptr_q[3:0]] <= {line_rx.ctrl, line_rx.word};
				wr_ptr_q <= wr_ptr_q + 5'd1;
			end
			if (pop)
				rd_ptr_q <= rd_ptr_q + 5'd1;
			bond_wait_q <= (bond_hit && skew_ok) ? bond_wait_q + 4'h1 : 4'h0; // RULE_15
		end
	end

	// ==========================================================
	// pattern generator and checker (prbs7/15/23/31 style lfsr picked by pat_sel, 32 bits per beat)
	function automatic logic [31:0] lfsr_step(input logic [31:0] s, input logic [1:0] sel);
		logic [31:0] v;
		logic        fb;
		v = s;
		for (int i = 0; i < 32; i++) begin
			unique case (sel)
				2'h0: fb = v[6] ^ v[5];
				2'h1: fb = v[14] ^ v[13];
				2'h2: fb = v[22] ^ v[17];
				default: fb = v[30] ^ v[27];
			endcase
			v = {v[30:0], fb};
		end
		lfsr_step = v;
	endfunction
	logic [31:0] tx_lfsr_q, rx_lfsr_q;
	logic        chk_err_q;
	wire  [31:0] rx_expect = lfsr_step(rx_lfsr_q, pat_sel);
	wire         inject    = err_loop ? chk_err_q : tx_pattern_error_inject; // RULE_14
	wire  [31:0] tx_pat    = lfsr_step(tx_lfsr_q, pat_sel) ^ {31'h0, inject}; // RULE_12 RULE_13
	wire         chk_mis   = prbs_en && line_lock && (line_rx.word != rx_expect); // RULE_11
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_lfsr_q <= lane_pkg::PRBS_SEED;
			rx_lfsr_q <= lane_pkg::PRBS_SEED;
			chk_err_q <= 1'b0;
			err_cnt_q <= 16'h0000;
		end else begin
			tx_lfsr_q <= lfsr_step(tx_lfsr_q, pat_sel);
			// checker self-synchronises on the received word, so one error also fails the next beat's check
			if (prbs_en && line_lock)
				rx_lfsr_q <= line_rx.word;
			chk_err_q <= chk_mis;
			if (chk_mis && err_cnt_q != 16'hFFFF)
				err_cnt_q <= err_cnt_q + 16'h0001;
		end
	end

	// ==========================================================
	// oob detect: count bursts of one kind before declaring a match
	logic [2:0] init_cnt_q, sas_cnt_q, wake_cnt_q;
	function automatic logic [2:0] bump(input logic [2:0] c, input logic b, input logic en);
		bump = !en ? 3'h0 : (b && c != 3'h7) ? c + 3'h1 : c;
	endfunction
	wire init_m = oob_en && (bump(init_cnt_q, line_oob_burst.init, 1'b1) >= burst_need);
	wire sas_m  = oob_en && (bump(sas_cnt_q, line_oob_burst.sas, 1'b1) >= burst_need);
	wire wake_m = oob_en && (bump(wake_cnt_q, line_oob_burst.wake, 1'b1) >= burst_need);

	// oob send: a request starts a fixed burst, then done pulses
	logic [3:0] send_cnt_q;
	wire        send_req = oob_init_send || oob_sas_send || oob_wake_send;

	// far receiver probe; only honoured in pcie coding with tx quiet in power state P1
	logic [5:0]       probe_cnt_q;
	lane_pkg::power_t tx_pw_q, rx_pw_q;
	wire probe_ok = far_rx_probe_req && !sata_fmt && tx_quiet_req
		&& (tx_power_state == lane_pkg::P1) && !tx_disp_force_mode; // RULE_05 RULE_06
	wire pw_change = (tx_power_state != tx_pw_q) || (rx_power_state != rx_pw_q); // RULE_09
	wire probe_end = (probe_cnt_q == 6'd1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_cnt_q <= 3'h0;
			sas_cnt_q  <= 3'h0;
			wake_cnt_q <= 3'h0;
			send_cnt_q <= 4'h0;
			probe_cnt_q <= 6'h00;
			tx_pw_q    <= lane_pkg::P0;
			rx_pw_q    <= lane_pkg::P0;
			oob_init_seen <= 1'b0;
			oob_sas_seen  <= 1'b0;
			oob_wake_seen <= 1'b0;
			oob_send_done <= 1'b0;
			phy_op_done   <= 1'b0;
			line_probe_active <= 1'b0;
			line_tx_oob_burst <= 1'b0;
		end else begin
			init_cnt_q <= init_m ? 3'h0 : bump(init_cnt_q, line_oob_burst.init, oob_en); // RULE_10
			sas_cnt_q  <= sas_m ? 3'h0 : bump(sas_cnt_q, line_oob_burst.sas, oob_en);
			wake_cnt_q <= wake_m ? 3'h0 : bump(wake_cnt_q, line_oob_burst.wake, oob_en);
			oob_init_seen <= init_m; // RULE_04 RULE_23
			oob_sas_seen  <= sas_m;
			oob_wake_seen <= wake_m;
			if (send_cnt_q == 4'h0 && send_req)
				send_cnt_q <= 4'(lane_pkg::BURST_CYC);
			else if (send_cnt_q != 4'h0)
				send_cnt_q <= send_cnt_q - 4'h1;
			line_tx_oob_burst <= (send_cnt_q > 4'h1) || (send_cnt_q == 4'h0 && send_req);
			oob_send_done <= (send_cnt_q == 4'h1); // RULE_25
			tx_pw_q <= tx_power_state;
			rx_pw_q <= rx_power_state;
			if (probe_cnt_q == 6'h00 && probe_ok)
				probe_cnt_q <= 6'(lane_pkg::PROBE_CYC);
			else if (probe_cnt_q != 6'h00)
				probe_cnt_q <= probe_cnt_q - 6'h01;
			line_probe_active <= (probe_cnt_q > 6'h01) || (probe_cnt_q == 6'h00 && probe_ok);
			phy_op_done <= probe_end || pw_change; // RULE_08
		end
	end

	// ==========================================================
	// outputs toward user and line
	logic       far_seen_q;
	logic [2:0] code_d;
	wire  [35:0] head = buf_mem[rd_ptr_q[3:0]];
	always_comb begin
		code_d = lane_pkg::ST_OK;
		if (probe_end && far_seen_q)
			code_d = lane_pkg::ST_DETECT;
		else if (sata_fmt && (oob_init_seen || oob_wake_seen))
			code_d = lane_pkg::ST_SATA_OOB;
		else if (chk_mis)
			code_d = lane_pkg::ST_ERR;
		else if (drop_now)
			code_d = lane_pkg::ST_DROP;
		else if (rm_hit && too_low)
			code_d = lane_pkg::ST_ADD;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			far_seen_q        <= 1'b0;
			rx_out            <= '0;
			rx_symbols_good   <= 1'b0;
			rx_condition_code <= lane_pkg::ST_OK;
			rx_pattern_error  <= 1'b0;
			line_tx_word      <= '0;
			line_tx_quiet     <= 1'b1;
		end else begin
			far_seen_q <= line_probe_active ? (far_seen_q | line_far_rx_present) : 1'b0;
			rx_out.word <= (loop_sel != 3'h0) ? tx_word_in : head[31:0]; // RULE_01
			rx_out.ctrl <= (loop_sel != 3'h0) ? 4'h0 : head[35:32];
			rx_symbols_good <= line_lock && ((fill != 5'd0) || loop_sel != 3'h0); // RULE_03
			rx_condition_code <= code_d; // RULE_02
			rx_pattern_error <= chk_mis;
			line_tx_word <= prbs_en ? tx_pat
				: (tx_disp_force_mode ? {32{tx_disp_force_value}} : tx_word_in);
			line_tx_quiet <= tx_quiet_req || (tx_power_state == lane_pkg::P2); // RULE_07
		end
	end
endmodule // lane_features

// ==== testbench/lane_props.sv ====
// concurrent checks on the lane feature block ports
`timescale 1ns/1ps
module lane_props (
	// clock and reset
	input wire logic             aclk,
	input wire logic             aresetn,
	// user side
	input wire logic             tx_quiet_req,
	input wire logic             far_rx_probe_req,
	input wire lane_pkg::power_t tx_power_state,
	input wire logic             oob_wake_send,
	input wire logic             oob_send_done,
	input wire logic             phy_op_done,
	input wire logic             oob_init_seen,
	input wire logic             oob_sas_seen,
	input wire logic             oob_wake_seen,
	input wire logic             rx_symbols_good,
	// line side
	input wire logic             line_lock,
	input wire logic             line_tx_quiet,
	input wire logic             line_tx_oob_burst,
	input wire logic             line_probe_active
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_quiet_hold: assert property ($past(tx_quiet_req) |-> line_tx_quiet)
		else $error("quiet lost");
	a_lock_valid: assert property (!line_lock [*3] |-> !rx_symbols_good)
		else $error("valid no lock");
	a_seen_pulse: assert property (oob_init_seen |-> !oob_sas_seen && !oob_wake_seen
		##1 !oob_init_seen) else $error("bad init flag");
	a_done_pulse: assert property (phy_op_done |=> !phy_op_done)
		else $error("done too long");
	a_power_done: assert property ($changed(tx_power_state) |-> ##[1:2] phy_op_done)
		else $error("no power done");
	a_probe_gate: assert property ($rose(line_probe_active) |-> $past(far_rx_probe_req)
		&& $past(tx_quiet_req) && $past(tx_power_state) == lane_pkg::P1)
		else $error("bad probe start");
	a_probe_span: assert property ($rose(line_probe_active) |-> line_probe_active [*8]
		##[30:34] !line_probe_active) else $error("bad probe length");
	a_probe_end: assert property ($fell(line_probe_active) |-> ##[0:1] phy_op_done)
		else $error("no probe done");
	a_burst_len: assert property ($rose(line_tx_oob_burst) |-> line_tx_oob_burst [*8]
		##1 !line_tx_oob_burst) else $error("bad burst length");
	a_send_done: assert property ($rose(oob_wake_send) |-> ##[1:16] oob_send_done)
		else $error("no send done");
endmodule // lane_props

// ==== testbench/line_model.sv ====
// line side model: received beats, lock, oob bursts and far receiver presence
`timescale 1ns/1ps
module line_model (
	// clock
	input wire logic            aclk,
	// bench control
	input wire lane_pkg::oob_t  kick,
	input wire logic            lock_en,
	input wire logic            present,
	// line outputs
	output lane_pkg::rx_beat_t  line_rx,
	output logic                line_lock,
	output lane_pkg::oob_t      line_oob_burst,
	output logic                line_far_rx_present
);
	integer         seed = 32'h4FE5;
	logic [3:0]     cnt_q = 4'h0;
	lane_pkg::oob_t kind_q = 3'h0;
	initial begin
		line_rx = '0;
		line_lock = 1'b0;
		line_oob_burst = 3'h0;
		line_far_rx_present = 1'b0;
	end
	// four bursts, one cycle each, with a gap between them
	always @(posedge aclk) begin
		line_lock <= lock_en;
		line_rx <= lock_en ? {32'($random(seed)), 4'h0} : ~line_rx;
		line_far_rx_present <= present;
		if (kick != 3'h0) begin
			kind_q <= kick;
			cnt_q <= 4'h8;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
		line_oob_burst <= cnt_q[0] ? kind_q : 3'h0;
	end
endmodule // line_model

// ==== testbench/tb_top.sv ====
// self-checking bench for the lane feature block
`timescale 1ns/1ps
module tb_top;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, tx_word_in = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	lane_pkg::rx_beat_t line_rx, rx_out;
	lane_pkg::oob_t line_oob_burst, kick = 3'h0;
	logic line_lock, line_far_rx_present, lock_en = 1'b0, present = 1'b0;
	logic far_rx_probe_req = 1'b0, tx_quiet_req = 1'b0, tx_pattern_error_inject = 1'b0;
	logic tx_disp_force_mode = 1'b0, tx_disp_force_value = 1'b0;
	logic oob_init_send = 1'b0, oob_sas_send = 1'b0, oob_wake_send = 1'b0;
	lane_pkg::power_t tx_power_state = lane_pkg::P0, rx_power_state = lane_pkg::P0;
	logic rx_symbols_good, oob_init_seen, oob_sas_seen, oob_wake_seen, oob_send_done;
	logic phy_op_done, rx_pattern_error, line_tx_quiet, line_tx_oob_burst, line_probe_active;
	logic [2:0] rx_condition_code;
	logic [31:0] line_tx_word;
	logic [33:0] exp_q[$];
	integer seed = 32'h4FE5;
	int bad_count = 0, cmp_count = 0, done_n = 0, phy_n = 0, det_n = 0, p;
	int seen_n[3] = '{0, 0, 0};
	lane_features dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_rx, .line_lock, .line_oob_burst,
		.line_far_rx_present, .far_rx_probe_req, .tx_quiet_req, .tx_power_state,
		.rx_power_state, .tx_disp_force_mode, .tx_disp_force_value, .tx_pattern_error_inject,
		.oob_init_send, .oob_sas_send, .oob_wake_send, .tx_word_in, .rx_out, .rx_symbols_good,
		.rx_condition_code, .oob_init_seen, .oob_sas_seen, .oob_wake_seen, .oob_send_done,
		.phy_op_done, .rx_pattern_error, .line_tx_word, .line_tx_quiet, .line_tx_oob_burst,
		.line_probe_active);
	line_model u_line (.aclk, .kick, .lock_en, .present, .line_rx, .line_lock,
		.line_oob_burst, .line_far_rx_present);
	initial begin
		forever #12.5 aclk = ~aclk;
	end
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ===========================================================
	// bus master; ready is read mid-cycle, so it is the value the next edge takes
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, wd;
		@(posedge aclk);
		{aw, wd} = 2'b00;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		while (!(aw && wd)) begin
			@(negedge aclk);
			aw |= s_axi_awready && s_axi_awvalid;
			wd |= s_axi_wready && s_axi_wvalid;
			@(posedge aclk);
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !wd;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		check(36'(s_axi_bresp), 36'h0);
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
		@(posedge aclk);
		exp_q.push_back(e);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axi_rvalid);
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	// ===========================================================
	// result watcher
	always @(negedge aclk) begin
		if (s_axi_rvalid && s_axi_rready)
			check({2'h0, s_axi_rresp, s_axi_rdata}, {2'h0, exp_q.pop_front()});
		seen_n[0] += int'(oob_init_seen);
		seen_n[1] += int'(oob_sas_seen);
		seen_n[2] += int'(oob_wake_seen);
		done_n += int'(oob_send_done);
		phy_n += int'(phy_op_done);
		det_n += int'(rx_condition_code == lane_pkg::ST_DETECT);
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(lane_pkg::ADDR_CTRL, {2'h0, lane_pkg::CTRL_RESET});
		axi_rd(8'h24, {2'h2, 32'h0});
		lock_en <= 1'b1;
		for (int m = 1; m < 8; m++) begin
			axi_wr(lane_pkg::ADDR_CTRL, lane_pkg::CTRL_RESET | 32'(m));
			axi_rd(lane_pkg::ADDR_CTRL, {2'h0, lane_pkg::CTRL_RESET | 32'(m)});
			tx_word_in <= $random(seed);
			tx_pattern_error_inject <= 1'($random(seed));
			repeat (20) @(posedge aclk);
			check(36'(rx_out.word), 36'(tx_word_in));
		end
		axi_wr(lane_pkg::ADDR_CTRL, lane_pkg::CTRL_RESET);
		repeat (20) @(posedge aclk);
		check(36'(rx_symbols_good), 36'h1);
		kick <= 3'b100;
		@(posedge aclk) kick <= 3'h0;
		repeat (20) @(posedge aclk);
		check(36'(seen_n[0]), 36'h0);
		axi_wr(lane_pkg::ADDR_CTRL, lane_pkg::CTRL_RESET | (32'h1 << lane_pkg::C_OOB_EN));
		for (int k = 0; k < 3; k++) begin
			kick <= 3'b100 >> k;
			{oob_init_send, oob_sas_send, oob_wake_send} <= 3'b100 >> k;
			@(posedge aclk) kick <= 3'h0;
			{oob_init_send, oob_sas_send, oob_wake_send} <= 3'h0;
			repeat (24) @(posedge aclk);
			check(36'(seen_n[k]), 36'h1);
			check(36'(done_n), 36'(k + 1));
		end
		lock_en <= 1'b0;
		{tx_quiet_req, present, tx_power_state} <= {2'b11, lane_pkg::P1};
		repeat (5) @(posedge aclk);
		check(36'(rx_symbols_good), 36'h0);
		p = phy_n;
		far_rx_probe_req <= 1'b1;
		@(posedge aclk) far_rx_probe_req <= 1'b0;
		repeat (60) @(posedge aclk);
		check(36'(phy_n), 36'(p + 1));
		check(36'(det_n), 36'h1);
		axi_wr(lane_pkg::ADDR_CTRL, lane_pkg::CTRL_RESET | (32'h1 << lane_pkg::C_SATA));
		p = phy_n;
		far_rx_probe_req <= 1'b1;
		@(posedge aclk) far_rx_probe_req <= 1'b0;
		repeat (60) @(posedge aclk);
		check(36'(phy_n), 36'(p));
		{tx_quiet_req, tx_power_state} <= {1'b0, lane_pkg::P0};
		repeat (4) @(posedge aclk);
		check(36'(line_tx_quiet), 36'h0);
		p = phy_n;
		rx_power_state <= lane_pkg::P2;
		repeat (4) @(posedge aclk);
		check(36'(phy_n), 36'(p + 1));
		report_and_stop();
	end
	// hang guard: run needs under two thousand cycles
	initial begin
		repeat (8000) @(posedge aclk);
		bad_count++;
		report_and_stop();
	end
endmodule // tb_top
bind lane_features lane_props u_props (.aclk, .aresetn, .tx_quiet_req, .far_rx_probe_req,
	.tx_power_state, .oob_wake_send, .oob_send_done, .phy_op_done, .oob_init_seen,
	.oob_sas_seen, .oob_wake_seen, .rx_symbols_good, .line_lock, .line_tx_quiet,
	.line_tx_oob_burst, .line_probe_active);
